// ### core/tcd_clock_dist.sv
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "tcd_consts.svh"
// Notes on behaviour
// [RULE1] Non-bonded: only serial clock delivered; each channel divides its own parallel clock.
// [RULE2] Bonded: serial and parallel clocks come from central divider in channel 1 or 4.
// [RULE3] Single-PLL line carries serial only, two banks, rate-limited, never bonded.
// [RULE4] Six-channel line carries both clocks from central divider to six channels.
// [RULE5] Side-wide line fed only from six-channel line, limited to 3125 Mbps.
// [RULE6] Single-PLL line serial reaches every divider of the two neighbouring banks.
// [RULE7] Channel whose PLL transmits loses its recovery unit; it becomes transmit-only.
// [RULE8] Bonded divider passes clocks through; non-bonded divider derives parallel clock.
// [RULE9] Bonded channels contiguous; only gap allowed is the source PLL channel.
// [RULE10] Divider feeds serial to serializer, parallel to serializer and transmit PCS.
// [RULE11] Byte serializer and transmit FIFO read run at parallel/2 when enabled.
// [RULE12] Transmit FIFO read clock forwarded to fabric as transmit clock out.
// [RULE13] Recovery unit divides recovered serial into recovered parallel clock.
// [RULE14] Without rate match FIFO, receive PCS runs on recovered parallel clock.
// [RULE15] With rate match FIFO, read side onward uses divider parallel clock.
// [RULE16] Byte deserializer read and byte ordering run at write clock over 1 or 2.
// [RULE17] Receive FIFO write clock is the divided clock, also forwarded to fabric.
// [RULE18] Receive bonding needs rate match FIFO; uses central divider parallel clock.
// [RULE19] Channels in source six use six-channel line; others use side-wide line.
// [RULE20] Only channel 1 and 4 PLLs reach the network.
// [RULE21] Selections are static: frozen while running.
module tcd_clock_dist #(
  parameter int NCH     = 12,
  parameter int PAR_DIV = 10,
  parameter bit FAST    = 1'b0
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic [NCH-1:0] pll_ser_tick,
  input  wire logic [NCH-1:0] cdr_ser_tick,
  output logic      [NCH-1:0] tx_ser_tick,
  output logic      [NCH-1:0] tx_par_tick,
  output logic      [NCH-1:0] tx_clkout,
  output logic      [NCH-1:0] rx_rec_par_tick,
  output logic      [NCH-1:0] rx_dec_tick,
  output logic      [NCH-1:0] rx_clkout,
  output logic      [NCH-1:0] tx_only
);
  localparam int IW = $clog2(NCH);
  localparam int DW = $clog2(PAR_DIV + 1);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [`TCD_W_CTRL-1:0] ctrl_r;
  logic [NCH-1:0]         mask_r;
  logic [15:0]            rate_r;
  logic                   start_r;
  logic                   run_r;
  logic                   wr_en;
  logic                   cfg_err;

  assign wr_en = psel && penable && pwrite;

  // Fields are frozen while running so no clock ever glitches mid-frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= `TCD_RST_CTRL;
      mask_r  <= '0;
      rate_r  <= `TCD_RST_RATE;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (wr_en && !run_r && !start_r) begin // see [RULE21]
        if (paddr == `TCD_OFF_CTRL) begin
          ctrl_r  <= pwdata[`TCD_W_CTRL-1:0];
          start_r <= pwdata[`TCD_B_RUN];
        end
        if (paddr == `TCD_OFF_TXMASK)
          mask_r <= pwdata[NCH-1:0];
        if (paddr == `TCD_OFF_RATE)
          rate_r <= pwdata[15:0];
      end
    end
  end

  // A start request only takes effect on a legal configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
    end else if (start_r) begin
      run_r <= !cfg_err; // see [RULE21]
    end else if (wr_en && paddr == `TCD_OFF_CTRL && !pwdata[`TCD_B_RUN]) begin
      run_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Source selection and legality
  // ----------------------------------------
  tcd_pkg::tcd_line_e line;
  logic [1:0]         pair;
  logic               bond;
  logic               rmf;
  logic               rxbond;
  logic [IW-1:0]      src_idx;
  logic [NCH-1:0]     src_bit;
  logic [NCH-1:0]     pair_mask;
  logic [NCH-1:0]     fill;
  logic [NCH-1:0]     low;
  logic               contig;
  logic               any_far;
  logic [15:0]        rate_lim;
  logic               e_line;
  logic               e_gap;
  logic               e_rxb;
  logic               e_rate;
  logic               e_src;
  logic [31:0]        src_full;

  assign line   = tcd_pkg::tcd_line_e'(ctrl_r[`TCD_B_LINE]);
  assign pair   = ctrl_r[`TCD_B_PAIR+1:`TCD_B_PAIR];
  assign bond   = ctrl_r[`TCD_B_BOND];
  assign rmf    = ctrl_r[`TCD_B_RMF];
  assign rxbond = ctrl_r[`TCD_B_RXBOND];
  // Only channel 1 or 4 of the pair may drive the network
  assign src_full = 32'(pair) * `TCD_CH_PER_PAIR
                  + (ctrl_r[`TCD_B_SRC4] ? `TCD_SRC_HIGH : `TCD_SRC_LOW); // see [RULE20]
  assign src_idx  = IW'(src_full);
  assign src_bit = NCH'(1) << src_idx;
  // Source PLL channel may sit inside the bonded run as its only gap
  assign fill    = mask_r | src_bit;
  assign low     = fill & (~fill + NCH'(1));
  assign contig  = ((fill + low) & fill) == '0; // see [RULE9]
  assign any_far = |(mask_r & ~pair_mask);
  assign rate_lim = (line == tcd_pkg::TCD_LINE_SIX && any_far) ? `TCD_RATE_SLOW // see [RULE5]
                  : (FAST ? `TCD_RATE_FAST : `TCD_RATE_SLOW); // see [RULE3]
  assign e_line  = bond && line == tcd_pkg::TCD_LINE_SINGLE; // see [RULE3]
  assign e_gap   = bond && !contig;
  assign e_rxb   = rxbond && !rmf; // see [RULE18]
  assign e_rate  = rate_r > rate_lim;
  // Pairs past the last channel would alias onto a real PLL once cut to the index width
  assign e_src   = src_full >= 32'(NCH); // see [RULE20]
  assign cfg_err = e_line || e_gap || e_rxb || e_rate || e_src;

  // ----------------------------------------
  // Central divider of the source channel
  // ----------------------------------------
  logic [DW-1:0] cen_cnt_r;
  logic          cen_par;
  logic          src_ser;

  assign src_ser = run_r && pll_ser_tick[src_idx];
  assign cen_par = src_ser && cen_cnt_r == DW'(PAR_DIV - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cen_cnt_r <= '0;
    else if (!run_r)
      cen_cnt_r <= '0;
    else if (src_ser)
      cen_cnt_r <= cen_par ? '0 : cen_cnt_r + DW'(1); // see [RULE4]
  end

  // ----------------------------------------
  // Per-channel dividers and PCS clock choice
  // ----------------------------------------
  logic [NCH-1:0] route;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [DW-1:0] loc_cnt_r;
    logic [DW-1:0] rec_cnt_r;
    logic          ser;
    logic          loc_par;
    logic          par;
    logic          rec_par;
    logic          cdr_ok;
    logic          dec;
    logic          tx_half_r;
    logic          rx_half_r;

    assign pair_mask[i] = 2'(i / 6) == pair;
    // Single-PLL line only reaches the two banks of its pair
    assign ser = run_r && mask_r[i] && pll_ser_tick[src_idx]
              && (line == tcd_pkg::TCD_LINE_SIX || pair_mask[i]); // see [RULE6]
    assign route[i] = line == tcd_pkg::TCD_LINE_SIX && !pair_mask[i]; // see [RULE19]
    assign loc_par = ser && loc_cnt_r == DW'(PAR_DIV - 1);
    assign par = bond ? (mask_r[i] && cen_par) : loc_par; // see [RULE8]
    // Recovery unit is lost when this channel's PLL drives transmit
    assign cdr_ok = !(run_r && src_idx == IW'(i)); // see [RULE7]
    assign rec_par = cdr_ok && cdr_ser_tick[i] && rec_cnt_r == DW'(PAR_DIV - 1);
    assign dec = !rmf ? rec_par // see [RULE14]
               : (rxbond ? (mask_r[i] && cen_par) : par); // see [RULE15] see [RULE18]

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        loc_cnt_r <= '0;
      else if (!run_r || bond)
        loc_cnt_r <= '0;
      else if (ser)
        loc_cnt_r <= loc_par ? '0 : loc_cnt_r + DW'(1); // see [RULE1]
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        rec_cnt_r <= '0;
      else if (!cdr_ok)
        rec_cnt_r <= '0;
      else if (cdr_ser_tick[i])
        rec_cnt_r <= rec_par ? '0 : rec_cnt_r + DW'(1); // see [RULE13]
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_half_r <= 1'b0;
        rx_half_r <= 1'b0;
      end else begin
        if (par)
          tx_half_r <= !tx_half_r;
        if (dec)
          rx_half_r <= !rx_half_r;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_ser_tick[i]     <= 1'b0;
        tx_par_tick[i]     <= 1'b0;
        tx_clkout[i]       <= 1'b0;
        rx_rec_par_tick[i] <= 1'b0;
        rx_dec_tick[i]     <= 1'b0;
        rx_clkout[i]       <= 1'b0;
      end else begin
        tx_ser_tick[i]     <= ser; // see [RULE10]
        tx_par_tick[i]     <= par; // see [RULE2]
        tx_clkout[i]       <= par && (!ctrl_r[`TCD_B_BSER] || tx_half_r); // see [RULE11] see [RULE12]
        rx_rec_par_tick[i] <= rec_par;
        rx_dec_tick[i]     <= dec;
        rx_clkout[i]       <= dec && (!ctrl_r[`TCD_B_BDES] || rx_half_r); // see [RULE16] see [RULE17]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tx_only <= '0;
    else
      tx_only <= run_r ? src_bit : '0; // see [RULE7]
  end

  // ----------------------------------------
  // APB read side
  // ----------------------------------------
  logic        hit;
  logic [31:0] rd_nxt;

  assign hit = paddr == `TCD_OFF_CTRL || paddr == `TCD_OFF_TXMASK || paddr == `TCD_OFF_RATE
            || paddr == `TCD_OFF_STATUS || paddr == `TCD_OFF_ROUTE;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_comb begin
    rd_nxt = '0;
    unique case (paddr)
      `TCD_OFF_CTRL: begin
        rd_nxt[`TCD_W_CTRL-1:0] = ctrl_r;
        rd_nxt[`TCD_B_RUN]      = run_r;
      end
      `TCD_OFF_TXMASK: rd_nxt[NCH-1:0] = mask_r;
      `TCD_OFF_RATE:   rd_nxt[15:0]    = rate_r;
      `TCD_OFF_STATUS: begin
        rd_nxt[`TCD_S_LINE_ERR] = e_line;
        rd_nxt[`TCD_S_GAP_ERR]  = e_gap;
        rd_nxt[`TCD_S_RXB_ERR]  = e_rxb;
        rd_nxt[`TCD_S_RATE_ERR] = e_rate;
        rd_nxt[`TCD_S_TXONLY]   = run_r;
        rd_nxt[`TCD_S_RUNNING]  = run_r;
      end
      `TCD_OFF_ROUTE:  rd_nxt[NCH-1:0] = route & mask_r;
      default:         rd_nxt = '0;
    endcase
  end

  // Captured in the setup cycle so data is from a flop when pready samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_nxt;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_gated: assert property (start_r && cfg_err |=> !run_r) // see [RULE21]
    else $error("run set on illegal configuration");
  a_no_single_bond: assert property (run_r |-> !(bond && line == tcd_pkg::TCD_LINE_SINGLE)) // see [RULE3]
    else $error("bonded on single-PLL line");
  a_bond_contig: assert property (run_r && bond |-> contig) // see [RULE9]
    else $error("bonded channels not contiguous");
  a_rxbond_rmf: assert property (run_r && rxbond |-> rmf) // see [RULE18]
    else $error("receive bonding without rate match");
  a_side_rate: assert property (run_r && any_far && line == tcd_pkg::TCD_LINE_SIX // see [RULE5]
                                |-> rate_r <= `TCD_RATE_SLOW)
    else $error("side-wide line over rate");
  a_cfg_frozen: assert property (run_r && $past(run_r) |-> $stable(ctrl_r) && $stable(mask_r)) // see [RULE21]
    else $error("configuration changed while running");
  a_src_no_cdr: assert property (run_r [*2] |-> !rx_rec_par_tick[src_idx]) // see [RULE7]
    else $error("recovered clock on transmit source channel");
  a_single_span: assert property ((run_r && line == tcd_pkg::TCD_LINE_SINGLE) [*2] // see [RULE6]
                                  |-> (tx_ser_tick & ~pair_mask) == '0)
    else $error("single-PLL line outside its pair");
  a_bond_par: assert property (run_r && bond && mask_r[0] && cen_par |=> tx_par_tick[0]) // see [RULE2]
    else $error("bonded parallel clock missing");

  // ----------------------------------------
  // Clock relations
  // ----------------------------------------
  a_txonly_src: assert property (run_r [*2] |-> tx_only == src_bit) // see [RULE7]
    else $error("transmit-only flag not on source channel");
  a_ser_masked: assert property ($stable(mask_r) // see [RULE10]
                                 |-> (tx_ser_tick & ~mask_r) == '0)
    else $error("serial clock on disabled channel");
  a_stop_idle: assert property (!run_r |=> tx_ser_tick == '0 && tx_par_tick == '0) // see [RULE10]
    else $error("transmit clocks while stopped");
  a_par_with_ser: assert property ((tx_par_tick & ~tx_ser_tick) == '0) // see [RULE8]
    else $error("parallel clock without serial clock");
  a_cen_range: assert property (cen_cnt_r < DW'(PAR_DIV)) // see [RULE4]
    else $error("central divider count out of range");
  a_txclk_in_par: assert property ((tx_clkout & ~tx_par_tick) == '0) // see [RULE12]
    else $error("forwarded transmit clock off a parallel tick");
  a_txclk_full: assert property (!ctrl_r[`TCD_B_BSER] && $stable(ctrl_r) // see [RULE11]
                                 |-> tx_clkout == tx_par_tick)
    else $error("forwarded transmit clock not at full rate");
  a_rxclk_in_dec: assert property ((rx_clkout & ~rx_dec_tick) == '0) // see [RULE17]
    else $error("forwarded receive clock off a decoder tick");
  a_rxclk_full: assert property (!ctrl_r[`TCD_B_BDES] && $stable(ctrl_r) // see [RULE16]
                                 |-> rx_clkout == rx_dec_tick)
    else $error("forwarded receive clock not at full rate");
  a_dec_recovered: assert property (!rmf && $stable(ctrl_r) // see [RULE14]
                                    |-> rx_dec_tick == rx_rec_par_tick)
    else $error("decoder clock not the recovered clock");
  a_rxbond_dec: assert property (rmf && rxbond && $stable(ctrl_r) // see [RULE18]
                                 && $stable(mask_r) |-> (rx_dec_tick & ~mask_r) == '0)
    else $error("bonded decoder clock on disabled channel");
endmodule

// ### core/tcd_consts.svh
`ifndef TCD_CONSTS_SVH
`define TCD_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TCD_OFF_CTRL    12'h000
`define TCD_OFF_TXMASK  12'h004
`define TCD_OFF_RATE    12'h008
`define TCD_OFF_STATUS  12'h00C
`define TCD_OFF_ROUTE   12'h010
// ----------------------------------------
// Control fields
// ----------------------------------------
`define TCD_B_RUN       0
`define TCD_B_BOND      1
`define TCD_B_LINE      2
`define TCD_B_SRC4      3
`define TCD_B_BSER      4
`define TCD_B_BDES      5
`define TCD_B_RMF       6
`define TCD_B_RXBOND    7
`define TCD_B_PAIR      8
`define TCD_W_CTRL      10
// ----------------------------------------
// Status fields
// ----------------------------------------
`define TCD_S_LINE_ERR  0
`define TCD_S_GAP_ERR   1
`define TCD_S_RXB_ERR   2
`define TCD_S_RATE_ERR  3
`define TCD_S_TXONLY    4
`define TCD_S_RUNNING   5
// ----------------------------------------
// Reset values and rate limits (Mbps)
// ----------------------------------------
`define TCD_RST_CTRL    10'h000
`define TCD_RST_RATE    16'h0C35
`define TCD_RATE_FAST   16'h1388
`define TCD_RATE_SLOW   16'h0C35
`define TCD_CH_PER_PAIR 32'h6
`define TCD_SRC_LOW     32'h1
`define TCD_SRC_HIGH    32'h4
`endif

// ### core/tcd_pkg.sv
package tcd_pkg;
  typedef enum logic {
    TCD_LINE_SINGLE,
    TCD_LINE_SIX
  } tcd_line_e;
endpackage

// ### test/tb.sv
`timescale 1ns/1ns
`include "tcd_consts.svh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, clr;
  logic [11:0] paddr, pll, cdr, tser, tpar, tco, rrec, rdec, rco, txo;
  logic [31:0] pwdata, prdata, q;
  int          failures, compares, n_ser, n_par, n_rec, n_dec, stray, n_rec1, n_tco, n_rco;
  int          cyc = 0;
  logic [31:0] m [4] = '{32'h1, 32'h1, 32'h1, 32'h9};
  logic [31:0] r [4] = '{`TCD_RST_RATE, `TCD_RST_RATE, `TCD_RATE_FAST, `TCD_RST_RATE};
  logic [31:0] c [4] = '{32'h3, 32'h87, 32'h1, 32'h7};
  int          eb [4] = '{0, 2, 3, 1};
  // PAR_DIV kept small so every divide is seen within a few ticks
  tcd_clock_dist #(.NCH(12), .PAR_DIV(2), .FAST(1'b0)) u_tcd_clock_dist (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_ser_tick(pll), .cdr_ser_tick(cdr), .tx_ser_tick(tser), .tx_par_tick(tpar),
    .tx_clkout(tco), .rx_rec_par_tick(rrec), .rx_dec_tick(rdec), .rx_clkout(rco),
    .tx_only(txo));
  tcd_fabric_model #(.NCH(12)) u_tcd_fabric_model (
    .pclk(pclk), .clr(clr), .tx_clkout(tco), .rx_clkout(rco),
    .tx_words(n_tco), .rx_words(n_rco));
  // ----------------------------------------
  // Clock, pulse counters, timeout
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (clr) begin
      n_ser = 0; n_par = 0; n_rec = 0; n_dec = 0; stray = 0; n_rec1 = 0;
    end else begin
      n_ser += int'(tser[0]);
      n_par += int'(tpar[0]);
      n_rec += int'(rrec[0]);
      n_dec += int'(rdec[0]);
      n_rec1 += int'(rrec[1]);
      stray += $countones(tser[11:1]);
    end
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Holds the request until pready is seen high; idle cycle after keeps drives apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic go(input logic [31:0] mk, input logic [31:0] rt, input logic [31:0] ct);
    apb(1'b1, `TCD_OFF_CTRL, 32'h0);
    apb(1'b1, `TCD_OFF_TXMASK, mk);
    apb(1'b1, `TCD_OFF_RATE, rt);
    apb(1'b1, `TCD_OFF_CTRL, ct);
    apb(1'b0, `TCD_OFF_STATUS, 32'h0);
  endtask
  task automatic tick(input logic [11:0] p, input logic [11:0] cd, input int k);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (k) begin
      pll <= p; cdr <= cd;
      @(posedge pclk);
      pll <= '0; cdr <= '0;
      @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    pll = '0; cdr = '0; clr = 1'b0; failures = 0; compares = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `TCD_OFF_CTRL, 32'h0);
    chk("ctrl", 32'h0, q);
    apb(1'b0, `TCD_OFF_RATE, 32'h0);
    chk("rate", 32'(`TCD_RST_RATE), q);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    $display("test reset values done");
    // Non-bonded, single-PLL line, source channel 1, channel 0 enabled
    go(32'h1, `TCD_RST_RATE, 32'h1);
    chk("status", 32'h20, q & 32'h2F);
    chk("tx only", 32'h2, {20'h0, txo});
    tick(12'h002, 12'h003, 4);
    chk("ser", 4, n_ser);
    chk("par", 2, n_par);
    chk("tx clkout", 2, n_tco);
    chk("stray", 0, stray);
    chk("rec par", 2, n_rec);
    chk("dec", 2, n_dec);
    chk("rx clkout", 2, n_rco);
    chk("rec src", 0, n_rec1);
    $display("test non-bonded done");
    // Bonded on six-channel line with byte paths and receive bonding
    go(32'h1, `TCD_RST_RATE, 32'hF7);
    chk("status", 32'h20, q & 32'h2F);
    tick(12'h002, 12'h000, 8);
    chk("ser", 8, n_ser);
    chk("par", 4, n_par);
    chk("tx clkout", 2, n_tco);
    chk("dec", 4, n_dec);
    chk("rec par", 0, n_rec);
    chk("rx clkout", 2, n_rco);
    $display("test bonded done");
    // Illegal starts: bonded single line, receive bond, rate, gap
    for (int i = 0; i < 4; i++) begin
      go(m[i], r[i], c[i]);
      chk("error bit", 32'h1, {31'h0, q[eb[i]]});
      chk("running", 32'h0, {31'h0, q[5]});
    end
    $display("test refused starts done");
    // Source on channel 4: channel 1's PLL no longer reaches the network, its CDR is back
    go(32'h1, `TCD_RST_RATE, 32'h9);
    chk("status", 32'h20, q & 32'h2F);
    chk("tx only", 32'h10, {20'h0, txo});
    tick(12'h002, 12'h002, 2);
    chk("ser off source", 0, n_ser);
    chk("rec ch1", 1, n_rec1);
    tick(12'h010, 12'h000, 2);
    chk("ser src4", 2, n_ser);
    chk("par src4", 1, n_par);
    $display("test source channel 4 done");
    // Channel 7 beyond the pair goes over the side-wide line; writes frozen while running
    go(32'h81, `TCD_RST_RATE, 32'h5);
    apb(1'b0, `TCD_OFF_ROUTE, 32'h0);
    chk("route", 32'h80, q);
    apb(1'b1, `TCD_OFF_TXMASK, 32'h3F);
    apb(1'b0, `TCD_OFF_TXMASK, 32'h0);
    chk("mask frozen", 32'h81, q);
    $display("test side-wide and static done");
    summarize();
  end
endmodule

// ### test/tcd_fabric_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Fabric side of the datapath interface
// ----------------------------------------
module tcd_fabric_model #(
  parameter int NCH = 12
) (
  input  wire logic           pclk,
  input  wire logic           clr,
  input  wire logic [NCH-1:0] tx_clkout,
  input  wire logic [NCH-1:0] rx_clkout,
  output int                  tx_words,
  output int                  rx_words
);
  // One word per forwarded edge on channel 0; no core clock of its own, so counts expose lost edges
  always @(posedge pclk) begin
    if (clr) begin
      tx_words = 0;
      rx_words = 0;
    end else begin
      tx_words += int'(tx_clkout[0]);
      rx_words += int'(rx_clkout[0]);
    end
  end
endmodule
